// ===== common/swl_pkg.sv
package swl_pkg;
  localparam int CLK_MHZ = 200;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;
  localparam int CNT_W = 16;
  localparam int IDX_W = 3;

  localparam logic [7:0] CMD_READ_BYTE = 8'h96;
  localparam logic [7:0] CMD_TRIPLET = 8'h78;
  localparam logic [2:0] READ_LAST_IDX = 3'h7;
  localparam logic [2:0] TRIP_LAST_IDX = 3'h2;
  localparam int READ_SLOTS = 8;
  localparam int TRIP_SLOTS = 3;

  // least times round up, a longest time rounds down
  function automatic int ns_to_cyc(input int ns);
    return (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction : ns_to_cyc

  localparam int ACT_MAX_PS = 262500;
  localparam int ACT_MAX_CYC = ACT_MAX_PS / CLK_PERIOD_PS;

  localparam int SLOT_STD_NS = 70000;
  localparam int W1L_STD_NS = 8000;
  localparam int W0L_STD_NS = 60000;
  localparam int MSR_STD_NS = 15000;
  localparam int SLOT_FAST_NS = 10000;
  localparam int W1L_FAST_NS = 1000;
  localparam int W0L_FAST_NS = 7500;
  localparam int MSR_FAST_NS = 2000;
  localparam int APU_NS = 500;
  localparam int SLOT_STD_CYC = ns_to_cyc(SLOT_STD_NS);
  localparam int W1L_STD_CYC = ns_to_cyc(W1L_STD_NS);
  localparam int W0L_STD_CYC = ns_to_cyc(W0L_STD_NS);
  localparam int MSR_STD_CYC = ns_to_cyc(MSR_STD_NS);
  localparam int SLOT_FAST_CYC = ns_to_cyc(SLOT_FAST_NS);
  localparam int W1L_FAST_CYC = ns_to_cyc(W1L_FAST_NS);
  localparam int W0L_FAST_CYC = ns_to_cyc(W0L_FAST_NS);
  localparam int MSR_FAST_CYC = ns_to_cyc(MSR_FAST_NS);
  localparam int APU_CYC = ns_to_cyc(APU_NS);

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RDATA = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;

  localparam int CTRL_SPEED_BIT = 0;
  localparam int CTRL_APU_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SBR_BIT = 5;
  localparam int STAT_TSB_BIT = 6;
  localparam int STAT_DIR_BIT = 7;
  localparam int DIR_VAL_BIT = 7;
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_REJECT_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } swl_state_t;
endpackage : swl_pkg

// ===== design/swl_sync.sv
module swl_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic pin_o
);
  import swl_pkg::*;
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      pin_o <= RST_VAL;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a level counts only once two stages agree
      if (s2_q == s3_q) begin
        pin_o <= s3_q;
      end
    end
  end
endmodule : swl_sync

// ===== design/swl_slot.sv
module swl_slot #(
  parameter int SLOT_STD = swl_pkg::SLOT_STD_CYC,
  parameter int W1L_STD = swl_pkg::W1L_STD_CYC,
  parameter int W0L_STD = swl_pkg::W0L_STD_CYC,
  parameter int MSR_STD = swl_pkg::MSR_STD_CYC,
  parameter int SLOT_FAST = swl_pkg::SLOT_FAST_CYC,
  parameter int W1L_FAST = swl_pkg::W1L_FAST_CYC,
  parameter int W0L_FAST = swl_pkg::W0L_FAST_CYC,
  parameter int MSR_FAST = swl_pkg::MSR_FAST_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic bit_i,
  input wire logic speed_i,
  input wire logic apu_i,
  input wire logic line_i,
  output logic line_o,
  output logic line_oe_o,
  output logic sample_o,
  output logic sample_val_o,
  output logic done_o
);
  import swl_pkg::*;
  localparam int CW = CNT_W;
  logic run_q;
  logic bit_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] slot_len;
  logic [CW-1:0] low_len;
  logic [CW-1:0] msr_at;
  logic low_d;
  logic apu_d;

  always_comb begin
    slot_len = speed_i ? CW'(SLOT_FAST) : CW'(SLOT_STD);
    msr_at = speed_i ? CW'(MSR_FAST) : CW'(MSR_STD);
    if (bit_q) begin
      low_len = speed_i ? CW'(W1L_FAST) : CW'(W1L_STD);
    end else begin
      low_len = speed_i ? CW'(W0L_FAST) : CW'(W0L_STD);
    end
    low_d = run_q && (cnt_q < low_len);
    // burst only after a write-zero: no slave can hold the line then
    apu_d = run_q && apu_i && !bit_q && (cnt_q >= low_len) &&
            (cnt_q < low_len + CW'(APU_CYC));
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
      bit_q <= 1'b1;
      cnt_q <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !run_q) begin
        run_q <= 1'b1;
        bit_q <= bit_i;
        cnt_q <= '0;
      end else if (run_q) begin
        cnt_q <= cnt_q + CW'(1);
        if (cnt_q == slot_len - CW'(1)) begin
          run_q <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_o <= 1'b0;
      line_oe_o <= 1'b0;
      sample_o <= 1'b0;
      sample_val_o <= 1'b1;
    end else begin
      line_o <= apu_d;
      line_oe_o <= low_d || apu_d;
      sample_o <= run_q && (cnt_q == msr_at);
      if (run_q && (cnt_q == msr_at)) begin
        sample_val_o <= line_i;
      end
    end
  end
endmodule : swl_slot

// ===== design/swl_top.sv
// Contract
// - 96h runs eight read slots into data
// - read-byte while busy: no ack, ignored
// - read-byte done in eight slots plus 262.5ns
// - read-byte line starts within 262.5ns
// - busy high for eight slots, then cleared
// - accepted command points reader at status
// - 78h runs two reads then one write
// - both reads zero: write direction value
// - 01 writes zero, 10/11 write one
// - triplet while busy: no acks, ignored
// - triplet done in three slots plus 262.5ns
// - triplet line starts within 262.5ns of MSB
// - busy three slots; result bits per sample
// - direction from bit 7, rest ignored
// - line bits go least significant first
//
// Chosen here: the register addresses and the Wishbone register port.
module swl_top #(
  parameter int SLOT_STD = swl_pkg::SLOT_STD_CYC,
  parameter int W1L_STD = swl_pkg::W1L_STD_CYC,
  parameter int W0L_STD = swl_pkg::W0L_STD_CYC,
  parameter int MSR_STD = swl_pkg::MSR_STD_CYC,
  parameter int SLOT_FAST = swl_pkg::SLOT_FAST_CYC,
  parameter int W1L_FAST = swl_pkg::W1L_FAST_CYC,
  parameter int W0L_FAST = swl_pkg::W0L_FAST_CYC,
  parameter int MSR_FAST = swl_pkg::MSR_FAST_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [swl_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [swl_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [swl_pkg::DATA_W-1:0] wb_dat_i,
  output logic [swl_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic cmd_valid_i,
  input wire logic [swl_pkg::BYTE_W-1:0] cmd_code_i,
  input wire logic ack_fall_i,
  input wire logic dir_msb_i,
  input wire logic dir_bit_i,
  input wire logic param_done_i,
  output logic cmd_ack_o,
  output logic cmd_nack_o,
  output logic dir_ack_o,
  output logic rdptr_status_o,
  output logic [swl_pkg::BYTE_W-1:0] status_o,
  output logic [swl_pkg::BYTE_W-1:0] rdata_o,
  input wire logic line_i,
  output logic line_o,
  output logic line_oe_o
);
  import swl_pkg::*;
  localparam int ActMax = ACT_MAX_CYC;

  swl_state_t state_q;
  logic trip_q;
  logic busy_q;
  logic dir_pend_q;
  logic [IDX_W-1:0] idx_q;
  logic go_q;
  logic slot_bit_q;
  logic dir_v_q;
  logic sbr_q;
  logic tsb_q;
  logic dirf_q;
  logic [BYTE_W-1:0] rdata_q;
  logic [1:0] ctrl_q;
  logic [IRQ_W-1:0] istat_q;
  logic [IRQ_W-1:0] imask_q;
  logic [IRQ_W-1:0] ev_set;
  logic line_s;
  logic smp;
  logic smp_val;
  logic sdone;
  logic ours;
  logic last;
  logic chosen;
  logic wb_hit;
  logic wb_wr;

  swl_sync #(.RST_VAL(1'b1)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pin_i(line_i),
    .pin_o(line_s)
  );

  swl_slot #(
    .SLOT_STD(SLOT_STD),
    .W1L_STD(W1L_STD),
    .W0L_STD(W0L_STD),
    .MSR_STD(MSR_STD),
    .SLOT_FAST(SLOT_FAST),
    .W1L_FAST(W1L_FAST),
    .W0L_FAST(W0L_FAST),
    .MSR_FAST(MSR_FAST)
  ) u_slot (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .start_i(go_q),
    .bit_i(slot_bit_q),
    .speed_i(ctrl_q[CTRL_SPEED_BIT]),
    .apu_i(ctrl_q[CTRL_APU_BIT]),
    .line_i(line_s),
    .line_o(line_o),
    .line_oe_o(line_oe_o),
    .sample_o(smp),
    .sample_val_o(smp_val),
    .done_o(sdone)
  );

  assign ours = (cmd_code_i == CMD_READ_BYTE) || (cmd_code_i == CMD_TRIPLET);
  assign last = trip_q ? (idx_q == TRIP_LAST_IDX) : (idx_q == READ_LAST_IDX);
  // write bit from the two reads and the direction value
  assign chosen = sbr_q ? 1'b1 : (smp_val ? 1'b0 : dir_v_q);

  // command acceptance and slot sequencing
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      trip_q <= 1'b0;
      busy_q <= 1'b0;
      idx_q <= '0;
      go_q <= 1'b0;
      slot_bit_q <= 1'b1;
      dir_v_q <= 1'b0;
      cmd_ack_o <= 1'b0;
      cmd_nack_o <= 1'b0;
      rdptr_status_o <= 1'b0;
    end else begin
      go_q <= 1'b0;
      cmd_ack_o <= 1'b0;
      cmd_nack_o <= 1'b0;
      rdptr_status_o <= 1'b0;
      if (cmd_valid_i && ours && busy_q) begin
        cmd_nack_o <= 1'b1;
      end
      case (state_q)
        ST_IDLE: begin
          if (cmd_valid_i && ours && !busy_q) begin
            cmd_ack_o <= 1'b1;
            rdptr_status_o <= 1'b1;
            busy_q <= 1'b1;
            trip_q <= (cmd_code_i == CMD_TRIPLET);
            idx_q <= '0;
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // the triplet starts on the MSB alone, before its byte ends
          if (!trip_q && ack_fall_i) begin
            go_q <= 1'b1;
            slot_bit_q <= 1'b1;
            state_q <= ST_RUN;
          end else if (trip_q && dir_msb_i) begin
            go_q <= 1'b1;
            slot_bit_q <= 1'b1;
            dir_v_q <= dir_bit_i;
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (sdone) begin
            if (last) begin
              busy_q <= 1'b0;
              state_q <= ST_IDLE;
            end else begin
              idx_q <= idx_q + IDX_W'(1);
              go_q <= 1'b1;
              if (trip_q && idx_q == TRIP_LAST_IDX - IDX_W'(1)) begin
                slot_bit_q <= dirf_q;
              end else begin
                slot_bit_q <= 1'b1;
              end
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // direction byte is acknowledged only for an accepted triplet
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dir_pend_q <= 1'b0;
      dir_ack_o <= 1'b0;
    end else begin
      dir_ack_o <= dir_pend_q && param_done_i;
      if (cmd_valid_i && !busy_q && state_q == ST_IDLE && cmd_code_i == CMD_TRIPLET) begin
        dir_pend_q <= 1'b1;
      end else if (param_done_i) begin
        dir_pend_q <= 1'b0;
      end
    end
  end

  // sampled results
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= BYTE_RST;
      sbr_q <= 1'b0;
      tsb_q <= 1'b0;
      dirf_q <= 1'b0;
    end else if (smp && state_q == ST_RUN) begin
      if (!trip_q) begin
        rdata_q[idx_q] <= smp_val;
      end else if (idx_q == '0) begin
        sbr_q <= smp_val;
      end else if (idx_q == IDX_W'(1)) begin
        tsb_q <= smp_val;
        dirf_q <= chosen;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_o <= BYTE_RST;
      rdata_o <= BYTE_RST;
    end else begin
      status_o <= BYTE_RST;
      status_o[STAT_BUSY_BIT] <= busy_q;
      status_o[STAT_SBR_BIT] <= sbr_q;
      status_o[STAT_TSB_BIT] <= tsb_q;
      status_o[STAT_DIR_BIT] <= dirf_q;
      rdata_o <= rdata_q;
    end
  end

  // register bus: ack one cycle after the request, writes land on the ack edge
  assign wb_hit = wb_cyc_i && wb_stb_i;
  assign wb_wr = wb_hit && wb_ack_o && wb_we_i && wb_sel_i[0];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_hit && !wb_ack_o;
      if (wb_hit && !wb_ack_o) begin
        wb_dat_o <= '0;
        if (wb_adr_i == REG_CTRL) begin
          wb_dat_o[1:0] <= ctrl_q;
        end else if (wb_adr_i == REG_STATUS) begin
          wb_dat_o[BYTE_W-1:0] <= status_o;
        end else if (wb_adr_i == REG_RDATA) begin
          wb_dat_o[BYTE_W-1:0] <= rdata_q;
        end else if (wb_adr_i == REG_IRQ_STAT) begin
          wb_dat_o[IRQ_W-1:0] <= istat_q;
        end else if (wb_adr_i == REG_IRQ_MASK) begin
          wb_dat_o[IRQ_W-1:0] <= imask_q;
        end
      end
    end
  end

  // speed and pullup are read live by the slot timer; change them only while idle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      imask_q <= IRQ_RST;
    end else if (wb_wr && wb_adr_i == REG_CTRL) begin
      ctrl_q <= wb_dat_i[1:0];
    end else if (wb_wr && wb_adr_i == REG_IRQ_MASK) begin
      imask_q <= wb_dat_i[IRQ_W-1:0];
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[IRQ_DONE_BIT] = state_q == ST_RUN && sdone && last;
    ev_set[IRQ_REJECT_BIT] = cmd_valid_i && ours && busy_q;
  end

  // a new event beats a simultaneous write-one clear
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      istat_q <= IRQ_RST;
      irq_o <= 1'b0;
    end else begin
      if (wb_wr && wb_adr_i == REG_IRQ_STAT) begin
        istat_q <= (istat_q & ~wb_dat_i[IRQ_W-1:0]) | ev_set;
      end else begin
        istat_q <= istat_q | ev_set;
      end
      irq_o <= |(istat_q & imask_q);
    end
  end

  // helper: cycles since the command's start reference
  logic [31:0] dur_q;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dur_q <= '0;
    end else if (state_q == ST_WAIT) begin
      dur_q <= '0;
    end else if (state_q == ST_RUN) begin
      dur_q <= dur_q + 32'h1;
    end
  end

  a_busy_refuse: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cmd_valid_i && ours && busy_q |=> cmd_nack_o && !cmd_ack_o && !rdptr_status_o)
    else $error("busy command was not refused");

  a_read_accept: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_code_i == CMD_READ_BYTE && !busy_q |=> cmd_ack_o && busy_q && !trip_q)
    else $error("idle read-byte not accepted");

  a_ptr_status: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cmd_ack_o |-> rdptr_status_o)
    else $error("read pointer not moved to status");

  a_read_start: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_q == ST_WAIT && !trip_q && ack_fall_i |-> ##[1:ActMax] line_oe_o)
    else $error("read-byte line activity late");

  a_trip_start: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_q == ST_WAIT && trip_q && dir_msb_i |-> ##[1:ActMax] line_oe_o)
    else $error("triplet line activity late");

  a_read_dur: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_q == ST_RUN && !trip_q && sdone && last |->
    dur_q <= READ_SLOTS * (ctrl_q[CTRL_SPEED_BIT] ? SLOT_FAST : SLOT_STD) + ActMax)
    else $error("read-byte took too long");

  a_trip_dur: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_q == ST_RUN && trip_q && sdone && last |->
    dur_q <= TRIP_SLOTS * (ctrl_q[CTRL_SPEED_BIT] ? SLOT_FAST : SLOT_STD) + ActMax)
    else $error("triplet took too long");

  a_busy_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_q == ST_RUN && sdone && last |=> !busy_q ##1 !status_o[STAT_BUSY_BIT])
    else $error("busy not cleared after last slot");

  a_lsb_first: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_q == ST_RUN && !trip_q && smp && idx_q == '0 |=> rdata_q[0] == $past(smp_val))
    else $error("first read slot not in bit 0");

  a_sbr_first: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_q == ST_RUN && trip_q && smp && idx_q == '0 |=> sbr_q == $past(smp_val) ##1 status_o[STAT_SBR_BIT] == sbr_q)
    else $error("single bit result not updated");

  a_write_pick: assert property (@(posedge core_clk_i) disable iff (rst_i)
    go_q && trip_q && idx_q == TRIP_LAST_IDX |->
    slot_bit_q == ((sbr_q || tsb_q) ? (sbr_q ? 1'b1 : 1'b0) : dir_v_q))
    else $error("triplet write slot value wrong");

  a_dir_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
    go_q && trip_q && idx_q == TRIP_LAST_IDX |-> slot_bit_q == dirf_q)
    else $error("direction flag differs from written bit");
endmodule : swl_top

// ===== verif/swl_wire_slave.sv
// behavioural slave on the single-wire line: answers read slots from tx_i and
// classifies each slot that the master drives by how long it held the line low
module swl_wire_slave #(
  parameter int HOLD_STD = 100,
  parameter int HOLD_FAST = 50,
  parameter int THR_STD = 85,
  parameter int THR_FAST = 45
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic mst_low_i,
  input wire logic speed_i,
  input wire logic [7:0] tx_i,
  output logic pull_o,
  output logic [7:0] wr_o,
  output logic [3:0] slots_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_q;
  int hold_q;
  int low_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
      hold_q <= 0;
      low_q <= 0;
      wr_o <= 8'h00;
      slots_o <= 4'h0;
    end else if (clr_i) begin
      hold_q <= 0;
      wr_o <= 8'h00;
      slots_o <= 4'h0;
    end else begin
      prev_q <= mst_low_i;
      if (mst_low_i && !prev_q) begin
        low_q <= 1;
        // a zero is held past the sample point but released before the slot ends
        hold_q <= tx_i[slots_o[2:0]] ? 0 : (speed_i ? HOLD_FAST : HOLD_STD);
      end else begin
        if (mst_low_i) low_q <= low_q + 1;
        if (hold_q != 0) hold_q <= hold_q - 1;
      end
      if (!mst_low_i && prev_q) begin
        wr_o[slots_o[2:0]] <= (low_q <= (speed_i ? THR_FAST : THR_STD));
        slots_o <= slots_o + 4'h1;
      end
    end
  end

  assign pull_o = (hold_q != 0);
endmodule : swl_wire_slave

// ===== verif/swl_top_bench.sv
module swl_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import swl_pkg::*;
  localparam int SLOT = 200;
  localparam int FSLOT = 100;
  localparam int ACT = ACT_MAX_CYC;
  localparam int W1L = 20, W0L = 150, MSR = 60, FW1L = 10, FW0L = 80, FMSR = 30;
  logic core_clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, clr = 0;
  logic cmd_valid = 0, ack_fall = 0, dir_msb = 0, dir_bit = 0, param_done = 0, spd = 0;
  logic [7:0] adr = 0, code = 0, tx = 0, status_o, rdata_o, wr;
  logic [3:0] sel = 0, slots, wsel = 4'hF;
  logic [31:0] wdat = 0, wb_dat_o, q;
  logic wb_ack_o, irq_o, cmd_ack_o, cmd_nack_o, dir_ack_o, rdptr_status_o, line_o, line_oe_o, pull, line_i;
  logic s_ack, s_nack, s_dir, s_rdp, s_apu;
  int n_fail = 0, checked = 0, t_oe, t_end;

  // pulled-up line: low while either side pulls it down
  assign line_i = !((line_oe_o && !line_o) || pull);

  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  swl_top #(.SLOT_STD(SLOT), .W1L_STD(W1L), .W0L_STD(W0L), .MSR_STD(MSR),
    .SLOT_FAST(FSLOT), .W1L_FAST(FW1L), .W0L_FAST(FW0L), .MSR_FAST(FMSR)) dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .cmd_valid_i(cmd_valid), .cmd_code_i(code), .ack_fall_i(ack_fall),
    .dir_msb_i(dir_msb), .dir_bit_i(dir_bit), .param_done_i(param_done), .cmd_ack_o(cmd_ack_o),
    .cmd_nack_o(cmd_nack_o), .dir_ack_o(dir_ack_o), .rdptr_status_o(rdptr_status_o),
    .status_o(status_o), .rdata_o(rdata_o), .line_i(line_i), .line_o(line_o), .line_oe_o(line_oe_o));

  swl_wire_slave slave (.core_clk_i(core_clk_i), .rst_i(rst_i), .clr_i(clr),
    .mst_low_i(line_oe_o && !line_o), .speed_i(spd), .tx_i(tx), .pull_o(pull), .wr_o(wr), .slots_o(slots));

  task automatic close_out;
    $display("mismatches=%0d comparisons=%0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge core_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= wsel;
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, k, 20);
      close_out();
    end
  endtask : wb

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rchk

  // edge 0 of the count is the edge that takes the caller's pulse
  task automatic run(input int lim, input logic trip, input logic intr);
    t_oe = lim;
    t_end = lim;
    {s_ack, s_nack, s_dir, s_rdp, s_apu} = 5'h0;
    for (int k = 0; k < lim; k++) begin
      @(posedge core_clk_i);
      ack_fall <= 1'b0;
      cmd_valid <= intr && (k == 100 || k == 300);
      code <= (intr && k > 200) ? CMD_TRIPLET : code;
      dir_msb <= intr && k == 310;
      param_done <= (trip && k == 20) || (intr && k == 330);
      #1;
      s_ack |= cmd_ack_o === 1'b1;
      s_nack |= cmd_nack_o === 1'b1;
      s_dir |= dir_ack_o === 1'b1;
      s_rdp |= rdptr_status_o === 1'b1;
      s_apu |= (line_oe_o && line_o) === 1'b1;
      if (line_oe_o === 1'b1 && t_oe == lim) t_oe = k;
      if (k > 5 && status_o[0] === 1'b0) begin
        t_end = k;
        break;
      end
    end
    if (lim > 9 && t_end == lim) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, t_end, lim);
      close_out();
    end
  endtask : run

  task automatic start(input logic [7:0] c, input logic [7:0] b, input logic s, input logic a);
    wb(1'b1, REG_CTRL, {30'h0, a, s}, q);
    spd <= s;
    tx <= b;
    @(posedge core_clk_i);
    clr <= 1'b1;
    @(posedge core_clk_i);
    clr <= 1'b0;
    cmd_valid <= 1'b1;
    code <= c;
    run(3, 1'b0, 1'b0);
  endtask : start

  task automatic rb(input logic [7:0] b, input logic s, input logic a, input logic intr);
    int sl;
    sl = s ? FSLOT : SLOT;
    start(CMD_READ_BYTE, b, s, a);
    chk(s_ack && s_rdp, 1'b1);
    chk(s_nack, 1'b0);
    @(posedge core_clk_i);
    ack_fall <= 1'b1;
    run(3000, 1'b0, intr);
    chk(t_oe <= ACT, 1'b1);
    chk(t_end >= 8 * sl, 1'b1);
    chk(t_end <= 8 * sl + ACT, 1'b1);
    chk(rdata_o, b);
    chk({wr, slots}, {8'hFF, 4'h8});
    chk(s_apu, 1'b0);
    if (intr) chk({s_nack, s_ack, s_dir}, 3'b100);
    rchk(REG_RDATA, {24'h0, b});
  endtask : rb

  function automatic logic exp_dir(input logic b1, input logic b2, input logic v);
    return (b1 == b2) ? (b1 | v) : b1;
  endfunction : exp_dir

  task automatic tr(input logic b1, input logic b2, input logic v, input logic s);
    logic d;
    int sl;
    logic a;
    d = exp_dir(b1, b2, v);
    sl = s ? FSLOT : SLOT;
    a = 1'($urandom);
    start(CMD_TRIPLET, {6'h0, b2, b1}, s, a);
    chk(s_ack && s_rdp, 1'b1);
    @(posedge core_clk_i);
    dir_msb <= 1'b1;
    dir_bit <= v;
    run(1500, 1'b1, 1'b0);
    chk(s_dir, 1'b1);
    chk(t_oe <= ACT, 1'b1);
    chk(t_end >= 3 * sl && t_end <= 3 * sl + ACT, 1'b1);
    chk(status_o[7:5], {d, b2, b1});
    chk({wr[2:0], slots}, {d, 2'b11, 4'h3});
    // the pullup burst follows only a written zero
    chk(s_apu, a && !d);
  endtask : tr

  initial begin
    q = $urandom(91409);
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk({status_o, rdata_o, irq_o, line_oe_o}, 18'h0);
    rchk(REG_CTRL, 32'h0);
    rchk(REG_IRQ_MASK, 32'h0);
    wb(1'b1, 8'h40, 32'hFFFFFFFF, q);
    rchk(8'h40, 32'h0);
    // a write without its low byte lane must leave the register alone
    wsel = 4'($urandom) & 4'hE;
    wb(1'b1, REG_CTRL, 32'h3, q);
    wsel = 4'hF;
    rchk(REG_CTRL, 32'h0);
    wb(1'b1, REG_IRQ_MASK, 32'h3, q);
    for (int i = 0; i < 6; i++) begin
      rb(i < 2 ? {8{i[0]}} : 8'($urandom), 1'($urandom), 1'($urandom), 1'b0);
      repeat (2) @(posedge core_clk_i);
      #1;
      chk(irq_o, 1'b1);
      rchk(REG_IRQ_STAT, 32'h1);
      wb(1'b1, REG_IRQ_STAT, 32'h1, q);
    end
    rb(8'($urandom), 1'b0, 1'b0, 1'b1);
    rchk(REG_IRQ_STAT, 32'h3);
    wb(1'b1, REG_IRQ_MASK, 32'h0, q);
    repeat (3) @(posedge core_clk_i);
    chk(irq_o, 1'b0);
    wb(1'b1, REG_IRQ_MASK, 32'h2, q);
    repeat (3) @(posedge core_clk_i);
    chk(irq_o, 1'b1);
    wb(1'b1, REG_IRQ_STAT, 32'h3, q);
    rchk(REG_IRQ_STAT, 32'h0);
    chk(irq_o, 1'b0);
    // walk every read pair, direction and speed, as a search would repeat it
    for (int i = 0; i < 16; i++) tr(i[0], i[1], i[2], i[3]);
    start(8'h5A, 8'hFF, 1'b0, 1'b0);
    chk({s_ack, s_nack, status_o[0]}, 3'b000);
    close_out();
  end
endmodule : swl_top_bench
